// ==== design/mdcp_params.svh ====
`ifndef MDCP_PARAMS_SVH
`define MDCP_PARAMS_SVH

// Clock period of ref_clk in ns
`define MDCP_CLK_NS 10
// Least time in us to cycles, rounded up
`define MDCP_US_UP(t) ((((t) * 1000) + `MDCP_CLK_NS - 1) / `MDCP_CLK_NS)
// Longest or nominal time in us to cycles, rounded down
`define MDCP_US_DN(t) (((t) * 1000) / `MDCP_CLK_NS)

// Average rotational wait, half a revolution
`define MDCP_LATENCY_US 100000
// Index pulse width
`define MDCP_INDEX_US 3500
// Carriage motion per track
`define MDCP_MOVE_US 5000
// Settling after the last motion
`define MDCP_SETTLE_US 20000
// Spin-up to ready
`define MDCP_SPINUP_US 500000
// Head engage, longest
`define MDCP_ENGAGE_US 30000
// Read recovery after unit or side choice
`define MDCP_READ_REC_US 100
// Write-to-read recovery
`define MDCP_W2R_US 1250
// Erase turn-on delay, longest
`define MDCP_ERASE_ON_US 450
// Erase hold after write ends, least
`define MDCP_ERASE_HOLD_US 900

// Tracks on the 48 tpi variant
`define MDCP_TRACKS 40
// Unit-choice lines
`define MDCP_UNITS 4
// Step command queue depth
`define MDCP_FIFO_DEPTH 4
// Cycles after reset release before straps are taken
`define MDCP_STRAP_WAIT 2'h3
// Stepper phase that belongs to the home cylinder
`define MDCP_HOME_PHASE 2'h0

`endif

// ==== design/mdcp_pkg.sv ====
package mdcp_pkg;

	// Carriage positioner states
	typedef enum logic [1:0] {POS_IDLE, POS_MOVE, POS_SETTLE} mdcp_pos_t;

	// Stepper motor phase
	typedef logic [1:0] mdcp_phase_t;

endpackage

// ==== design/mdcp_fifo.sv ====
`timescale 1ns/1ps
`include "mdcp_params.svh"

module mdcp_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = `MDCP_FIFO_DEPTH
)(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	import mdcp_pkg::*;

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH]; // Storage words
	logic [AW-1:0] wr_q; // Write pointer
	logic [AW-1:0] rd_q; // Read pointer
	logic [AW:0] cnt_q; // Words held
	logic push;
	logic pop;

	// Depth below two leaves no room for pointers
	if (DEPTH < 2 || WIDTH < 1)
	begin : g_chk
		$error("mdcp_fifo: DEPTH must be at least 2");
	end

	// Pointer advance with wrap for any depth
	function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	assign in_ready = (cnt_q != (AW + 1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Storage, no reset needed for data
	always_ff @(posedge ref_clk)
	begin
		if (push)
		begin
			mem[wr_q] <= in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_q <= next_ptr(wr_q);
			end
			if (pop)
			begin
				rd_q <= next_ptr(rd_q);
			end
			if (push && !pop)
			begin
				cnt_q <= cnt_q + 1'b1;
			end
			else if (pop && !push)
			begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

endmodule

// ==== design/mdcp_position.sv ====
`timescale 1ns/1ps
`include "mdcp_params.svh"

module mdcp_position #(
	parameter int TRACKS = `MDCP_TRACKS,
	parameter int TW = $clog2(`MDCP_TRACKS),
	parameter int MOVE_CYC = `MDCP_US_DN(`MDCP_MOVE_US),
	parameter int SETTLE_CYC = `MDCP_US_UP(`MDCP_SETTLE_US)
)(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic cmd_valid,
	input wire logic cmd_dir,
	output logic cmd_ready,
	output logic [TW-1:0] track,
	output mdcp_pkg::mdcp_phase_t phase,
	output mdcp_pkg::mdcp_pos_t state
);
	import mdcp_pkg::*;

	mdcp_pos_t state_q; // Positioner state
	logic [31:0] cnt_q; // Motion or settle timer
	logic dir_q; // Direction of the move in flight
	logic [TW-1:0] track_q; // Current cylinder
	mdcp_phase_t phase_q; // Energised stepper phase
	logic move_end;

	if (MOVE_CYC < 1 || SETTLE_CYC < 1 || TRACKS < 2)
	begin : g_chk
		$error("mdcp_position: bad timing or track count");
	end

	assign move_end = (state_q == POS_MOVE) && (cnt_q == 32'(MOVE_CYC - 1));
	// Queue drains only between motions
	assign cmd_ready = (state_q != POS_MOVE);
	assign track = track_q;
	assign phase = phase_q;
	assign state = state_q;

	// Motion then settle; a queued step skips the settle so a
	// long seek pays settling once only
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			state_q <= POS_IDLE;
			cnt_q <= '0;
			dir_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				POS_IDLE:
				begin
					if (cmd_valid)
					begin
						state_q <= POS_MOVE;
						cnt_q <= '0;
						dir_q <= cmd_dir;
					end
				end
				POS_MOVE:
				begin
					cnt_q <= move_end ? '0 : cnt_q + 32'h1;
					if (move_end)
					begin
						state_q <= POS_SETTLE;
					end
				end
				POS_SETTLE:
				begin
					if (cmd_valid)
					begin
						state_q <= POS_MOVE;
						cnt_q <= '0;
						dir_q <= cmd_dir;
					end
					else if (cnt_q == 32'(SETTLE_CYC - 1))
					begin
						state_q <= POS_IDLE;
						cnt_q <= '0;
					end
					else
					begin
						cnt_q <= cnt_q + 32'h1;
					end
				end
			endcase
		end
	end

	// Track and phase change at the end of each motion; the stops
	// at both ends hold the carriage
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			track_q <= '0;
			phase_q <= `MDCP_HOME_PHASE;
		end
		else if (move_end)
		begin
			if (dir_q && track_q != TW'(TRACKS - 1))
			begin
				track_q <= track_q + 1'b1;
				phase_q <= phase_q + 1'b1;
			end
			else if (!dir_q && track_q != '0)
			begin
				track_q <= track_q - 1'b1;
				phase_q <= phase_q - 1'b1;
			end
		end
	end

	property p_inward;
		@(posedge ref_clk) disable iff (reset)
		move_end && dir_q && track_q != TW'(TRACKS - 1) |=> track_q == $past(track_q) + 1'b1;
	endproperty
	a_inward: assert property (p_inward) else $error("inward step lost");

	property p_motion;
		@(posedge ref_clk) disable iff (reset)
		$changed(track_q) |-> $past(cnt_q) == 32'(MOVE_CYC - 1) && $past(state_q) == POS_MOVE;
	endproperty
	a_motion: assert property (p_motion) else $error("track changed off motion end");

endmodule

// ==== design/mdcp_drive.sv ====
`timescale 1ns/1ps
`include "mdcp_params.svh"

module mdcp_drive #(
	parameter int UNITS = `MDCP_UNITS,
	parameter int TRACKS = `MDCP_TRACKS,
	localparam int SW = $clog2(UNITS),
	localparam int TW = $clog2(TRACKS),
	parameter int MOVE_CYC = `MDCP_US_DN(`MDCP_MOVE_US),
	parameter int SETTLE_CYC = `MDCP_US_UP(`MDCP_SETTLE_US),
	parameter int SPIN_CYC = `MDCP_US_UP(`MDCP_SPINUP_US),
	parameter int REV_CYC = `MDCP_US_DN(2 * `MDCP_LATENCY_US),
	parameter int INDEX_CYC = `MDCP_US_DN(`MDCP_INDEX_US),
	parameter int ENGAGE_CYC = `MDCP_US_DN(`MDCP_ENGAGE_US),
	parameter int READ_REC_CYC = `MDCP_US_UP(`MDCP_READ_REC_US),
	parameter int W2R_CYC = `MDCP_US_UP(`MDCP_W2R_US),
	parameter int ERASE_ON_CYC = `MDCP_US_DN(`MDCP_ERASE_ON_US),
	parameter int ERASE_HOLD_CYC = `MDCP_US_UP(`MDCP_ERASE_HOLD_US)
)(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [SW-1:0] strap_unit,
	input wire logic strap_perm,
	input wire logic [UNITS-1:0] unit_sel,
	input wire logic motor_on,
	input wire logic head_load,
	input wire logic side_sel,
	input wire logic step_pulse,
	input wire logic step_dir,
	input wire logic write_arm,
	input wire logic write_data,
	input wire logic door_closed,
	input wire logic power_ok,
	input wire logic notch_covered,
	output logic ready,
	output logic index_mark,
	output logic home_cylinder_flag,
	output logic medium_lock,
	output logic panel_lamp,
	output logic spindle_run,
	output logic head_solenoid,
	output logic heads_engaged,
	output logic head1_route,
	output logic write_circuits,
	output logic erase_current,
	output logic flux_toggle,
	output logic read_stable,
	output logic [TW-1:0] track,
	output logic step_overrun,
	output logic seek_busy
);
	import mdcp_pkg::*;

	localparam int NPIN = UNITS + SW + 11;

	logic [NPIN-1:0] meta_q; // First synchroniser stage
	logic [NPIN-1:0] sync_q; // Second stage, safe to read
	logic [UNITS-1:0] unit_s;
	logic [SW-1:0] strap_unit_s;
	logic strap_perm_s;
	logic motor_s;
	logic head_load_s;
	logic side_s;
	logic step_s;
	logic dir_s;
	logic arm_s;
	logic wdata_s;
	logic door_s;
	logic power_s;
	logic notch_s;
	logic [1:0] strap_wait_q; // Delay before straps are taken
	logic [SW-1:0] strap_unit_q; // Unit number strap
	logic strap_perm_q; // Always-chosen strap
	logic sel_q; // This unit is chosen
	logic sel_prev_q;
	logic side_prev_q;
	logic spun_q; // Spin-up time elapsed
	logic [31:0] spin_cnt_q;
	logic [31:0] rev_cnt_q; // Revolution phase
	logic [31:0] hl_cnt_q; // Head engage timer
	logic [31:0] er_cnt_q; // Erase on or hold timer
	logic [31:0] rec_cnt_q; // Read recovery timer
	logic ready_q;
	logic index_q;
	logic home_q;
	logic lock_q;
	logic lamp_q;
	logic spin_q;
	logic sol_q;
	logic engaged_q;
	logic head1_q;
	logic write_q;
	logic erase_q;
	logic flux_q;
	logic stable_q;
	logic overrun_q;
	logic busy_q;
	logic step_prev_q;
	logic wd_prev_q;
	logic step_rise;
	logic wd_rise;
	logic wr_ok;
	logic engage_req;
	logic q_valid;
	logic q_ready;
	logic q_out_valid;
	logic q_out_dir;
	logic q_out_ready;
	logic [TW-1:0] pos_track;
	mdcp_phase_t pos_phase;
	mdcp_pos_t pos_state;

	if (UNITS < 2 || REV_CYC <= INDEX_CYC || SPIN_CYC < 1)
	begin : g_chk
		$error("mdcp_drive: bad unit count or timing");
	end

	// Keep the longer of a running and a new recovery time
	function automatic logic [31:0] longer(input logic [31:0] a, input logic [31:0] b);
		return (a > b) ? a : b;
	endfunction

	assign {unit_s, strap_unit_s, strap_perm_s, motor_s, head_load_s, side_s, step_s,
		dir_s, arm_s, wdata_s, door_s, power_s, notch_s} = sync_q;
	assign step_rise = step_s && !step_prev_q;
	assign wd_rise = wdata_s && !wd_prev_q;
	// Writing needs the unit chosen and an open notch
	assign wr_ok = sel_q && arm_s && !notch_s;
	assign engage_req = sel_q && head_load_s && motor_s;
	// Steps count only for the chosen unit
	assign q_valid = step_rise && sel_q;

	// All pins cross in through two flip-flops
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= {unit_sel, strap_unit, strap_perm, motor_on, head_load, side_sel,
				step_pulse, step_dir, write_arm, write_data, door_closed, power_ok,
				notch_covered};
			sync_q <= meta_q;
		end
	end

	// Straps are caught once, after the synchroniser has filled
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			strap_wait_q <= '0;
			strap_unit_q <= '0;
			strap_perm_q <= 1'b0;
		end
		else if (strap_wait_q != `MDCP_STRAP_WAIT)
		begin
			strap_wait_q <= strap_wait_q + 1'b1;
			strap_unit_q <= strap_unit_s;
			strap_perm_q <= strap_perm_s;
		end
	end

	// Unit choice, lamp, side routing, edge history
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			sel_q <= 1'b0;
			sel_prev_q <= 1'b0;
			side_prev_q <= 1'b0;
			lamp_q <= 1'b0;
			head1_q <= 1'b0;
			step_prev_q <= 1'b0;
			wd_prev_q <= 1'b0;
		end
		else
		begin
			sel_q <= strap_perm_q || unit_s[strap_unit_q];
			sel_prev_q <= sel_q;
			side_prev_q <= side_s;
			lamp_q <= sel_q;
			head1_q <= sel_q && side_s;
			step_prev_q <= step_s;
			wd_prev_q <= wdata_s;
		end
	end

	// Spindle: timed spin-up, no run-down when stopped
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			spin_q <= 1'b0;
			spun_q <= 1'b0;
			spin_cnt_q <= '0;
			ready_q <= 1'b0;
		end
		else
		begin
			spin_q <= motor_s;
			if (!motor_s)
			begin
				spun_q <= 1'b0;
				spin_cnt_q <= '0;
			end
			else if (!spun_q)
			begin
				spun_q <= (spin_cnt_q == 32'(SPIN_CYC - 1));
				spin_cnt_q <= spin_cnt_q + 32'h1;
			end
			// Speed is judged by elapsed spin-up time, not a tacho
			ready_q <= power_s && door_s && spun_q;
		end
	end

	// Index mark once per revolution while turning
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			rev_cnt_q <= '0;
			index_q <= 1'b0;
		end
		else if (!motor_s)
		begin
			rev_cnt_q <= '0;
			index_q <= 1'b0;
		end
		else
		begin
			rev_cnt_q <= (rev_cnt_q == 32'(REV_CYC - 1)) ? '0 : rev_cnt_q + 32'h1;
			index_q <= (rev_cnt_q < 32'(INDEX_CYC));
		end
	end

	// Head solenoid and engaged status
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			sol_q <= 1'b0;
			engaged_q <= 1'b0;
			hl_cnt_q <= '0;
		end
		else
		begin
			sol_q <= engage_req;
			if (!engage_req)
			begin
				engaged_q <= 1'b0;
				hl_cnt_q <= '0;
			end
			else if (!engaged_q)
			begin
				// Reported as engaged at the longest engage time
				engaged_q <= (hl_cnt_q == 32'(ENGAGE_CYC - 1));
				hl_cnt_q <= hl_cnt_q + 32'h1;
			end
		end
	end

	// Write circuits, erase current and flux reversals
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			write_q <= 1'b0;
			erase_q <= 1'b0;
			er_cnt_q <= '0;
			flux_q <= 1'b0;
			lock_q <= 1'b0;
		end
		else
		begin
			write_q <= wr_ok;
			lock_q <= sel_q && notch_s;
			if (notch_s)
			begin
				// Protected medium: erase cut at once
				erase_q <= 1'b0;
				er_cnt_q <= '0;
			end
			else if (wr_ok != erase_q)
			begin
				// Deselection ends the write too, so hold still runs
				if (er_cnt_q == 32'(wr_ok ? ERASE_ON_CYC - 1 : ERASE_HOLD_CYC - 1))
				begin
					erase_q <= wr_ok;
					er_cnt_q <= '0;
				end
				else
				begin
					er_cnt_q <= er_cnt_q + 32'h1;
				end
			end
			else
			begin
				er_cnt_q <= '0;
			end
			if (wd_rise && write_q)
			begin
				flux_q <= !flux_q;
			end
		end
	end

	// Read recovery after choice, side change or end of write
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			rec_cnt_q <= '0;
			stable_q <= 1'b0;
		end
		else
		begin
			if (write_q && !wr_ok)
			begin
				rec_cnt_q <= longer(rec_cnt_q, 32'(W2R_CYC));
			end
			else if ((sel_q && !sel_prev_q) || (side_s != side_prev_q))
			begin
				rec_cnt_q <= longer(rec_cnt_q, 32'(READ_REC_CYC));
			end
			else if (rec_cnt_q != '0)
			begin
				rec_cnt_q <= rec_cnt_q - 32'h1;
			end
			stable_q <= sel_q && !write_q && (rec_cnt_q == '0);
		end
	end

	// Step queue; a step into a full queue is flagged, not taken
	mdcp_fifo #(
		.WIDTH(1),
		.DEPTH(`MDCP_FIFO_DEPTH)
	) u_step_q (
		.ref_clk(ref_clk),
		.reset(reset),
		.in_valid(q_valid),
		.in_data(dir_s),
		.in_ready(q_ready),
		.out_valid(q_out_valid),
		.out_data(q_out_dir),
		.out_ready(q_out_ready)
	);

	mdcp_position #(
		.TRACKS(TRACKS),
		.TW(TW),
		.MOVE_CYC(MOVE_CYC),
		.SETTLE_CYC(SETTLE_CYC)
	) u_pos (
		.ref_clk(ref_clk),
		.reset(reset),
		.cmd_valid(q_out_valid),
		.cmd_dir(q_out_dir),
		.cmd_ready(q_out_ready),
		.track(pos_track),
		.phase(pos_phase),
		.state(pos_state)
	);

	// Positioner status toward the pins
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			overrun_q <= 1'b0;
			busy_q <= 1'b0;
			home_q <= 1'b0;
		end
		else
		begin
			overrun_q <= q_valid && !q_ready;
			busy_q <= (pos_state != POS_IDLE) || q_out_valid;
			home_q <= power_s && (pos_track == '0) && (pos_phase == `MDCP_HOME_PHASE);
		end
	end

	assign ready = ready_q;
	assign index_mark = index_q;
	assign home_cylinder_flag = home_q;
	assign medium_lock = lock_q;
	assign panel_lamp = lamp_q;
	assign spindle_run = spin_q;
	assign head_solenoid = sol_q;
	assign heads_engaged = engaged_q;
	assign head1_route = head1_q;
	assign write_circuits = write_q;
	assign erase_current = erase_q;
	assign flux_toggle = flux_q;
	assign read_stable = stable_q;
	assign track = pos_track;
	assign step_overrun = overrun_q;
	assign seek_busy = busy_q;

	property p_stop;
		@(posedge ref_clk) disable iff (reset)
		!motor_s |=> !spun_q ##1 !ready_q;
	endproperty
	a_stop: assert property (p_stop) else $error("spindle ran down");

	property p_spinup;
		@(posedge ref_clk) disable iff (reset)
		$rose(spun_q) |-> $past(spin_cnt_q) == 32'(SPIN_CYC - 1);
	endproperty
	a_spinup: assert property (p_spinup) else $error("spin-up time wrong");

	property p_ready;
		@(posedge ref_clk) disable iff (reset)
		ready_q |-> $past(power_s) && $past(door_s) && $past(spun_q);
	endproperty
	a_ready: assert property (p_ready) else $error("ready without cause");

	property p_lock;
		@(posedge ref_clk) disable iff (reset)
		notch_s |=> !write_q && !erase_q;
	endproperty
	a_lock: assert property (p_lock) else $error("write on covered notch");

	property p_erase_on;
		@(posedge ref_clk) disable iff (reset)
		$rose(erase_q) |-> $past(er_cnt_q) == 32'(ERASE_ON_CYC - 1) && $past(wr_ok);
	endproperty
	a_erase_on: assert property (p_erase_on) else $error("erase on time wrong");

	property p_erase_hold;
		@(posedge ref_clk) disable iff (reset)
		$fell(erase_q) && !$past(notch_s) |-> $past(er_cnt_q) == 32'(ERASE_HOLD_CYC - 1);
	endproperty
	a_erase_hold: assert property (p_erase_hold) else $error("erase hold too short");

	property p_engage;
		@(posedge ref_clk) disable iff (reset)
		$rose(engaged_q) |-> $past(hl_cnt_q) == 32'(ENGAGE_CYC - 1) && sol_q;
	endproperty
	a_engage: assert property (p_engage) else $error("engage time wrong");

	property p_w2r;
		@(posedge ref_clk) disable iff (reset)
		$fell(write_q) |-> !stable_q [*3];
	endproperty
	a_w2r: assert property (p_w2r) else $error("read stable after write");

	property p_flux;
		@(posedge ref_clk) disable iff (reset)
		$changed(flux_q) |-> $past(wd_rise) && $past(write_q);
	endproperty
	a_flux: assert property (p_flux) else $error("stray flux reversal");

	property p_lamp;
		@(posedge ref_clk) disable iff (reset)
		!strap_perm_q && !unit_s[strap_unit_q] && strap_wait_q == `MDCP_STRAP_WAIT
			|=> ##1 !lamp_q;
	endproperty
	a_lamp: assert property (p_lamp) else $error("lamp lit when not chosen");

	property p_home;
		@(posedge ref_clk) disable iff (reset)
		home_q |-> $past(pos_track) == '0;
	endproperty
	a_home: assert property (p_home) else $error("home flag off cylinder zero");

	property p_index;
		@(posedge ref_clk) disable iff (reset)
		$rose(index_q) && $past(motor_s, 2) |-> $past(rev_cnt_q) == '0;
	endproperty
	a_index: assert property (p_index) else $error("index off revolution start");

endmodule

// ==== tb/mdcp_ctrl_model.sv ====
`timescale 1ns/1ps

module mdcp_ctrl_model #(
	parameter int DIR_WAIT = 8
)(
	input wire logic ref_clk,
	output logic step_pulse,
	output logic step_dir
);
	// Step line idles inactive, direction starts outward
	initial
	begin
		step_pulse = 1'h0;
		step_dir = 1'h0;
	end

	// One track-move pulse held w cycles; widths scale with the shortened motion
	task step(input logic d, input int w);
		if (d !== step_dir)
		begin
			@(posedge ref_clk) step_dir <= d;
			repeat (DIR_WAIT) @(posedge ref_clk);
		end
		@(posedge ref_clk) step_pulse <= 1'h1;
		repeat (w) @(posedge ref_clk);
		step_pulse <= 1'h0;
		@(posedge ref_clk);
	endtask
endmodule

// ==== tb/mdcp_drive_test.sv ====
`timescale 1ns/1ps

module mdcp_drive_test;
	// Shortened counts, all expectations derive from these
	localparam int MV = 20;
	localparam int ST = 40;
	localparam int SP = 50;
	localparam int RV = 100;
	localparam int IX = 10;
	localparam int EN = 15;
	localparam int WR = 25;
	localparam int EO = 9;
	localparam int EH = 18;
	logic ref_clk = 1'h0;
	logic reset = 1'h1;
	logic [1:0] strap_unit = 2'h2;
	logic strap_perm = 1'h0;
	logic [3:0] unit_sel = 4'h0;
	logic motor_on = 1'h0;
	logic head_load = 1'h0;
	logic side_sel = 1'h0;
	logic write_arm = 1'h0;
	logic write_data = 1'h0;
	logic door_closed = 1'h1;
	logic power_ok = 1'h1;
	logic notch_covered = 1'h0;
	logic step_pulse, step_dir, ready, index_mark, home_cylinder_flag, medium_lock;
	logic panel_lamp, spindle_run, head_solenoid, heads_engaged, head1_route;
	logic write_circuits, erase_current, flux_toggle, read_stable, step_overrun, seek_busy;
	logic [5:0] track;
	logic ovr = 1'h0; // Sticky overrun catch
	logic f; // Flux level before a burst
	int n_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	// Watched levels, indexed by the wait task
	wire logic [7:0] obs = {panel_lamp, index_mark, write_circuits, seek_busy,
		read_stable, erase_current, heads_engaged, ready};

	always #5 ref_clk = ~ref_clk;

	// Controller side of the step and direction lines
	mdcp_ctrl_model ctl (.ref_clk, .step_pulse, .step_dir);

	mdcp_drive #(.MOVE_CYC(MV), .SETTLE_CYC(ST), .SPIN_CYC(SP), .REV_CYC(RV),
		.INDEX_CYC(IX), .ENGAGE_CYC(EN), .READ_REC_CYC(8), .W2R_CYC(WR),
		.ERASE_ON_CYC(EO), .ERASE_HOLD_CYC(EH)) dut (
		.ref_clk, .reset, .strap_unit, .strap_perm, .unit_sel, .motor_on,
		.head_load, .side_sel, .step_pulse, .step_dir, .write_arm, .write_data,
		.door_closed, .power_ok, .notch_covered, .ready, .index_mark,
		.home_cylinder_flag, .medium_lock, .panel_lamp, .spindle_run,
		.head_solenoid, .heads_engaged, .head1_route, .write_circuits,
		.erase_current, .flux_toggle, .read_stable, .track, .step_overrun,
		.seek_busy);

	// Cycle count for the hang guard, overrun pulse is one cycle so latch it
	always @(posedge ref_clk)
	begin
		cycles++;
		if (step_overrun === 1'h1)
			ovr <= 1'h1;
		if (cycles == 5000)
		begin
			n_errors++;
			give_verdict;
		end
	end

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask

	// Wait for obs[i]==v on falling edges; not before lo cycles, not after hi
	task wt(input int i, input logic v, input int lo, input int hi);
		int k;
		k = 0;
		while (obs[i] !== v && k < hi)
		begin
			@(negedge ref_clk);
			k++;
		end
		chk({7'h00, obs[i] === v && k >= lo}, 8'h01);
	endtask

	task cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		cyc(8);
		chk(obs, 8'h00);
		chk({2'h0, track}, 8'h00);
		repeat (8) @(posedge ref_clk);
		reset <= 1'h0;
		cyc(8);
		chk(home_cylinder_flag, 1'h1);
		// Only the strapped unit line lights the lamp
		@(posedge ref_clk) unit_sel <= 4'h2;
		cyc(6);
		chk(panel_lamp, 1'h0);
		@(posedge ref_clk) unit_sel <= 4'h4;
		wt(7, 1'h1, 1, 6);
		$display("unit choice done");
		// Spin-up, index period and width, ready gating
		@(posedge ref_clk) motor_on <= 1'h1;
		wt(0, 1'h1, SP, SP + 8);
		chk(spindle_run, 1'h1);
		wt(6, 1'h1, 0, RV);
		wt(6, 1'h0, IX, IX + 1);
		wt(6, 1'h1, RV - IX - 1, RV - IX + 1);
		@(posedge ref_clk) power_ok <= 1'h0;
		wt(0, 1'h0, 1, 6);
		@(posedge ref_clk) power_ok <= 1'h1;
		wt(0, 1'h1, 1, 6);
		// An open door drops ready as well
		@(posedge ref_clk) door_closed <= 1'h0;
		wt(0, 1'h0, 1, 6);
		@(posedge ref_clk) door_closed <= 1'h1;
		wt(0, 1'h1, 1, 6);
		$display("spindle done");
		// Heads engage, then side routing settled before any transfer
		@(posedge ref_clk) head_load <= 1'h1;
		wt(1, 1'h1, EN, EN + 6);
		chk(head_solenoid, 1'h1);
		@(posedge ref_clk) side_sel <= 1'h1;
		cyc(8);
		chk(head1_route, 1'h1);
		@(posedge ref_clk) side_sel <= 1'h0;
		cyc(8);
		chk(head1_route, 1'h0);
		$display("head done");
		// One inward track, then one long outward pulse that must act once
		ctl.step(1'h1, 2);
		wt(4, 1'h1, 0, 6);
		wt(4, 1'h0, MV + ST, MV + ST + 4);
		chk({2'h0, track}, 8'h01);
		chk(home_cylinder_flag, 1'h0);
		ctl.step(1'h0, MV + ST + 20);
		cyc(8);
		chk(seek_busy, 1'h0);
		chk({2'h0, track}, 8'h00);
		chk(home_cylinder_flag, 1'h1);
		// Burst overfills the step queue; one settle after the last move
		repeat (7) ctl.step(1'h1, 2);
		wt(4, 1'h0, 4 * MV, 6 * MV + ST);
		chk(ovr, 1'h1);
		chk({2'h0, track}, 8'h06);
		@(posedge ref_clk) unit_sel <= 4'h1;
		cyc(4);
		ctl.step(1'h1, 2);
		cyc(10);
		chk({seek_busy, track}, 8'h06);
		@(posedge ref_clk) unit_sel <= 4'h4;
		cyc(12);
		// Read retry fallback: step three tracks off, come back, check the track
		repeat (3) ctl.step(1'h0, 2);
		repeat (3) ctl.step(1'h1, 2);
		wt(4, 1'h0, 6 * MV, 6 * MV + ST);
		chk({2'h0, track}, 8'h06);
		$display("stepping done");
		// Write arm, delayed erase, flux per data rise, recovery
		@(posedge ref_clk) write_arm <= 1'h1;
		wt(5, 1'h1, 1, 6);
		wt(2, 1'h1, EO - 1, EO + 3);
		f = flux_toggle;
		repeat (3)
		begin
			@(posedge ref_clk) write_data <= 1'h1;
			repeat (2) @(posedge ref_clk);
			write_data <= 1'h0;
			repeat (2) @(posedge ref_clk);
		end
		cyc(6);
		chk(flux_toggle, !f);
		chk(read_stable, 1'h0);
		@(posedge ref_clk) write_arm <= 1'h0;
		wt(2, 1'h0, EH, EH + 6);
		wt(3, 1'h1, WR - EH - 2, WR - EH + 4);
		// Covered notch blocks write and erase; four attempts, then give up
		@(posedge ref_clk) notch_covered <= 1'h1;
		repeat (4)
		begin
			@(posedge ref_clk) write_arm <= 1'h1;
			cyc(EO + 10);
			chk({medium_lock, write_circuits, erase_current}, 8'h04);
			@(posedge ref_clk) write_arm <= 1'h0;
			cyc(4);
		end
		@(posedge ref_clk) notch_covered <= 1'h0;
		$display("write done");
		// Stop is immediate, no run-down
		@(posedge ref_clk) motor_on <= 1'h0;
		wt(0, 1'h0, 1, 6);
		chk(spindle_run, 1'h0);
		$display("stop done");
		// Always-chosen strap, taken only at a fresh reset
		@(posedge ref_clk) reset <= 1'h1;
		strap_perm <= 1'h1;
		unit_sel <= 4'h0;
		repeat (4) @(posedge ref_clk);
		reset <= 1'h0;
		wt(7, 1'h1, 4, 8);
		$display("strap done");
		give_verdict;
	end
endmodule
